/* File: src/ddc_dual_dac_ctrl.sv */
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - power-up clears both dac registers to zero
// - mode bits 17,16 apply only on load
// - modes: normal, 1k, 100k, high impedance
// - channels power down independently, on load
// - power-down shuts amp, switches output network
// - exit needs normal-mode write then load
// - word: rsv,rsv,ldb,lda,x,sel,pd1,pd0,data
// - no load bits: write selected buffer only
// - load a: write buffer, copy a to dac
// - load a with sel b uses old buffer
// - both loads update both channels together
// - load copies data and mode, starts conversion
// - command acts on 24th falling sclk edge; here that edge queues the word, run from the fifo when hold is clear
// - sample din on falling sclk, sync low
// - early sync rise discards partial word
module ddc_dual_dac_ctrl
  import ddc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // serial link pins, asynchronous to clock
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic link_busy,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog core drive
  output ddc_pkg::ddc_analog_s ana_a,
  output ddc_pkg::ddc_analog_s ana_b
);
  import ddc_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic sclk_prev; // last synced sclk level, for the falling edge
    logic [4:0] bit_cnt; // bits taken in this frame
    logic [23:0] shift; // serial shift register
    logic push_v; // completed word on its way to the fifo
    ddc_word_s push_w; // that word
    ddc_chan_s buf_a; // data buffer a
    ddc_chan_s buf_b; // data buffer b
    ddc_chan_s dac_a; // dac register a
    ddc_chan_s dac_b; // dac register b
    ddc_analog_s ana_a; // analog drive a
    ddc_analog_s ana_b; // analog drive b
    logic hold; // software stall of the executor
    logic ovf; // sticky: a word found the fifo full
    logic link_busy; // fifo cannot take a word
    logic [31:0] prdata; // apb read data
    logic pready; // apb answer
    logic pslverr; // apb error
  } ddc_state_s;
  ddc_state_s s_q;
  ddc_state_s s_d;

  logic sclk_s; // synced sclk
  logic sync_n_s; // synced frame select
  logic din_s; // synced data
  logic fifo_in_ready; // fifo has room
  logic fifo_out_valid; // fifo holds a word
  logic [FIFO_WIDTH-1:0] fifo_out_data; // oldest word
  logic [FIFO_LVL_W-1:0] fifo_level; // words held
  ddc_word_s cmd; // word being executed
  logic exec; // word executed this cycle
  logic sclk_fall; // falling edge of sclk seen
  logic apb_setup; // first cycle of an apb transfer
  logic apb_wr; // apb write taking effect

  // pins cross into the clock domain before anything looks at them
  ddc_sync #(
    .N(3)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({sclk, sync_n, din}),
    .q({sclk_s, sync_n_s, din_s})
  );

  // words wait here so software can stall execution with the hold bit
  ddc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(s_q.push_v),
    .in_ready(fifo_in_ready),
    .in_data(s_q.push_w),
    .out_valid(fifo_out_valid),
    .out_ready(!s_q.hold),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign cmd = ddc_word_s'(fifo_out_data);
  assign exec = fifo_out_valid && !s_q.hold;
  assign sclk_fall = s_q.sclk_prev && !sclk_s;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && s_q.pready;

  // read mux, also used to flag unmapped addresses
  function automatic logic [32:0] ddc_read(ddc_state_s s, logic [7:0] a,
                                            logic [FIFO_LVL_W-1:0] lvl);
    logic [32:0] r;
    r = '0;
    case (a)
      REG_CTRL: r[CTRL_HOLD_BIT] = s.hold;
      REG_STATUS:
      begin
        r[STATUS_OVF_BIT] = s.ovf;
        r[STATUS_LVL_LSB +: FIFO_LVL_W] = lvl;
      end
      REG_DAC_A: r[17:0] = s.dac_a;
      REG_DAC_B: r[17:0] = s.dac_b;
      REG_BUF_A: r[17:0] = s.buf_a;
      REG_BUF_B: r[17:0] = s.buf_b;
      default: r[32] = 1'b1; // unmapped: error, data zero
    endcase
    return r;
  endfunction

  // next state of the whole block
  always_comb
  begin
    ddc_chan_s nc; // channel contents carried by the word
    logic [32:0] rd; // read mux result
    logic ld_a; // channel a loaded now
    logic ld_b; // channel b loaded now
    nc = '0;
    rd = '0;
    ld_a = 1'b0;
    ld_b = 1'b0;
    s_d = s_q;
    s_d.push_v = 1'b0;
    s_d.sclk_prev = sclk_s;

    // serial capture
    if (sync_n_s)
    begin
      // frame idle or cut short: drop any partial word
      s_d.bit_cnt = '0;
      s_d.shift = '0;
    end
    else if (sclk_fall && s_q.bit_cnt != BIT_CNT_FULL)
    begin
      // bits after the 24th are ignored until sync rises
      s_d.shift = {s_q.shift[22:0], din_s};
      s_d.bit_cnt = s_q.bit_cnt + 5'h01;
      if (s_q.bit_cnt == BIT_CNT_LAST)
      begin
        s_d.push_v = 1'b1;
        s_d.push_w = ddc_word_s'({s_q.shift[22:0], din_s});
      end
    end

    // apb: answer is prepared in the setup cycle, so the access phase has no wait
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata = '0;
    if (apb_setup)
    begin
      rd = ddc_read(s_q, paddr, fifo_level);
      s_d.pready = 1'b1;
      s_d.pslverr = rd[32];
      s_d.prdata = pwrite ? 32'h00000000 : rd[31:0];
    end
    if (apb_wr && !s_q.pslverr)
    begin
      if (paddr == REG_CTRL)
        s_d.hold = pwdata[CTRL_HOLD_BIT];
      if (paddr == REG_STATUS && pwdata[STATUS_OVF_BIT])
        s_d.ovf = 1'b0; // write one to clear
    end

    // a word arriving at a full fifo is lost; the flag set beats a clear
    if (s_q.push_v && !fifo_in_ready)
      s_d.ovf = 1'b1;
    s_d.link_busy = !fifo_in_ready;

    // command execution; reserved top bits are not checked
    if (exec)
    begin
      nc.mode = ddc_mode_e'({cmd.power_mode_hi, cmd.power_mode_lo});
      nc.data = cmd.data;
      // the selected buffer is always written first
      if (cmd.buf_sel)
        s_d.buf_b = nc;
      else
        s_d.buf_a = nc;
      ld_a = cmd.load_chan_a;
      ld_b = cmd.load_chan_b;
      // a load copies the buffer as it stands after this write
      if (ld_a)
        s_d.dac_a = cmd.buf_sel ? s_q.buf_a : nc;
      if (ld_b)
        s_d.dac_b = cmd.buf_sel ? nc : s_q.buf_b;
    end

    // analog drive follows the dac register; modes change only through a load
    s_d.ana_a = ddc_drive(s_d.dac_a, ld_a);
    s_d.ana_b = ddc_drive(s_d.dac_b, ld_b);
  end

  // state register; reset gives zero-scale, normal mode, empty buffers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.dac_a <= {DDC_NORMAL, DATA_RST};
      s_q.dac_b <= {DDC_NORMAL, DATA_RST};
      s_q.buf_a <= {DDC_NORMAL, DATA_RST};
      s_q.buf_b <= {DDC_NORMAL, DATA_RST};
      s_q.hold <= CTRL_HOLD_RST;
      s_q.ana_a <= {1'b1, 1'b0, 1'b0, 1'b0, DATA_RST};
      s_q.ana_b <= {1'b1, 1'b0, 1'b0, 1'b0, DATA_RST};
    end
    else
      s_q <= s_d;
  end

  // outputs straight from the state register
  assign link_busy = s_q.link_busy;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign ana_a = s_q.ana_a;
  assign ana_b = s_q.ana_b;

  default clocking ddc_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_word_on_24th :
    assert property (!sync_n_s && sclk_fall && s_q.bit_cnt == BIT_CNT_LAST |=> s_q.push_v)
    else $error("24th falling edge did not complete a word");
  a_abort_clears :
    assert property (sync_n_s |=> s_q.bit_cnt == '0 && s_q.shift == '0)
    else $error("frame select high did not clear capture");
  a_no_extra_bits :
    assert property (s_q.bit_cnt == BIT_CNT_FULL && !sync_n_s |=> s_q.bit_cnt == BIT_CNT_FULL)
    else $error("bits taken after the 24th edge");
  a_buffer_only :
    assert property (exec && !cmd.load_chan_a && !cmd.load_chan_b
                     |=> $stable(s_q.dac_a) && $stable(s_q.dac_b) && !ana_a.conv_start)
    else $error("buffer-only write changed a dac register");
  a_load_a_copy :
    assert property (exec && cmd.load_chan_a && !cmd.buf_sel
                     |=> s_q.dac_a.data == $past(cmd.data) && ana_a.conv_start)
    else $error("load a did not take the new word");
  a_load_a_old_buf :
    assert property (exec && cmd.load_chan_a && cmd.buf_sel
                     |=> s_q.dac_a == $past(s_q.buf_a))
    else $error("load a with buffer b did not use buffer a");
  a_both_loads :
    assert property (exec && cmd.load_chan_a && cmd.load_chan_b
                     |=> ana_a.conv_start && ana_b.conv_start)
    else $error("both loads did not update together");
  a_pd_output :
    assert property (ana_a.amp_on == (s_q.dac_a.mode == DDC_NORMAL)
                     && ana_b.sw_100k == (s_q.dac_b.mode == DDC_PD_100K))
    else $error("analog drive disagrees with mode");
  a_apb_answer :
    assert property (apb_setup |=> pready ##1 !pready)
    else $error("apb answer not a single cycle after setup");

  // per-channel loads: the unselected buffer must never leak into the other channel

  a_load_b_copy :
    assert property (exec && cmd.load_chan_b && cmd.buf_sel
                     |=> s_q.dac_b == $past(fifo_out_data[17:0]) && ana_b.conv_start)
    else $error("load b did not take the new word");

  a_load_b_stale :
    assert property (exec && cmd.load_chan_b && !cmd.buf_sel
                     |=> s_q.dac_b == $past(s_q.buf_b) && ana_b.conv_start)
    else $error("load b with buffer a did not use buffer b");

  a_unloaded_a_kept :
    assert property (exec && !cmd.load_chan_a
                     |=> $stable(s_q.dac_a) && !ana_a.conv_start)
    else $error("channel a changed without its load");

  a_unloaded_b_kept :
    assert property (exec && !cmd.load_chan_b
                     |=> $stable(s_q.dac_b) && !ana_b.conv_start)
    else $error("channel b changed without its load");

  a_dac_needs_exec :
    assert property (!exec |=> $stable(s_q.dac_a) && $stable(s_q.dac_b))
    else $error("dac register changed without a command");

  a_no_stray_conv :
    assert property (!exec |=> !ana_a.conv_start && !ana_b.conv_start)
    else $error("conversion started without a load");

  // buffer writes: only the selected buffer moves

  a_write_buf_a :
    assert property (exec && !cmd.buf_sel
                     |=> s_q.buf_a == $past(fifo_out_data[17:0]) && $stable(s_q.buf_b))
    else $error("buffer a write went astray");

  a_write_buf_b :
    assert property (exec && cmd.buf_sel
                     |=> s_q.buf_b == $past(fifo_out_data[17:0]) && $stable(s_q.buf_a))
    else $error("buffer b write went astray");

  // serial capture: one bit per falling edge, whole word handed on

  a_shift_on_fall :
    assert property (!sync_n_s && sclk_fall && s_q.bit_cnt != BIT_CNT_FULL
                     |=> s_q.shift[0] == $past(din_s))
    else $error("falling edge did not take the data bit");

  a_push_whole_word :
    assert property (s_q.push_v |-> s_q.push_w == ddc_word_s'(s_q.shift))
    else $error("pushed word differs from the shift register");

  a_idle_no_push :
    assert property (sync_n_s |=> !s_q.push_v)
    else $error("word pushed while frame select was high");

  // analog switch network against the mode held in the dac register

  a_mode_1k_switch :
    assert property (s_q.dac_b.mode == DDC_PD_1K
                     |-> ana_b.sw_1k && !ana_b.amp_on && !ana_b.sw_100k)
    else $error("1k mode did not close the 1k switch");

  a_hiz_all_open :
    assert property (s_q.dac_a.mode == DDC_PD_HIZ
                     |-> !ana_a.amp_on && !ana_a.sw_1k && !ana_a.sw_100k)
    else $error("high impedance mode left a path closed");

  a_normal_drive :
    assert property (s_q.dac_b.mode == DDC_NORMAL
                     |-> ana_b.amp_on && !ana_b.sw_1k && !ana_b.sw_100k)
    else $error("normal mode did not drive from the amplifier");
endmodule // ddc_dual_dac_ctrl

/* File: common/ddc_pkg.sv */
package ddc_pkg;
  // serial word geometry
  localparam int WORD_BITS = 24;
  localparam logic [4:0] BIT_CNT_LAST = 5'h17; // count before the 24th falling edge
  localparam logic [4:0] BIT_CNT_FULL = 5'h18; // word complete, later bits ignored
  // word buffer between the link and the executor
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 24;
  localparam int FIFO_LVL_W = 4;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DAC_A = 8'h08;
  localparam logic [7:0] REG_DAC_B = 8'h0C;
  localparam logic [7:0] REG_BUF_A = 8'h10;
  localparam logic [7:0] REG_BUF_B = 8'h14;
  // field positions
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STATUS_OVF_BIT = 0;
  localparam int STATUS_LVL_LSB = 8;
  localparam int CHAN_MODE_LSB = 16;
  // values after reset
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic CTRL_HOLD_RST = 1'b0;

  // channel operating mode, encoded as the two mode bits of the word
  typedef enum logic [1:0] {DDC_NORMAL, DDC_PD_1K, DDC_PD_100K, DDC_PD_HIZ} ddc_mode_e;

  // one serial command word, top bit first
  typedef struct packed {
    logic [1:0] reserved;
    logic load_chan_b;
    logic load_chan_a;
    logic ignored_bit;
    logic buf_sel;
    logic power_mode_hi;
    logic power_mode_lo;
    logic [15:0] data;
  } ddc_word_s;

  // contents of a data buffer or dac register
  typedef struct packed {
    ddc_mode_e mode;
    logic [15:0] data;
  } ddc_chan_s;

  // drive of one analog channel
  typedef struct packed {
    logic amp_on;
    logic sw_1k;
    logic sw_100k;
    logic conv_start;
    logic [15:0] code;
  } ddc_analog_s;

  // analog drive from a channel's dac register; shared by both channels
  function automatic ddc_analog_s ddc_drive(ddc_chan_s c, logic start);
    ddc_analog_s a;
    a.amp_on = (c.mode == DDC_NORMAL);
    a.sw_1k = (c.mode == DDC_PD_1K);
    a.sw_100k = (c.mode == DDC_PD_100K);
    a.conv_start = start;
    a.code = c.data;
    return a;
  endfunction
endpackage

/* File: src/ddc_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for pin levels; first stage feeds only the second
module ddc_sync #(
  parameter int N = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [N-1:0] d,
  output logic [N-1:0] q
);
  typedef struct packed {
    logic [N-1:0] s1; // metastability catch
    logic [N-1:0] s2; // settled level
  } ddc_sync_s;
  ddc_sync_s s_q;
  ddc_sync_s s_d;

  // shift each bit two stages deep
  always_comb
  begin
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q = s_q.s2;
endmodule // ddc_sync

/* File: src/ddc_fifo.sv */
`timescale 1ns/1ps
// word fifo with show-ahead output and honest full/empty
module ddc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH); // count that means full
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // words held
  } ddc_fifo_s;
  ddc_fifo_s s_q;
  ddc_fifo_s s_d;
  logic push;
  logic pop;

  assign in_ready = (s_q.cnt != FULL_CNT);
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign level = s_q.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update; simultaneous push and pop keep the count
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + AW'(1);
    end
    if (pop)
      s_d.rp = s_q.rp + AW'(1);
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  a_fifo_no_over :
    assert property (@(posedge clock) disable iff (!rst_n) s_q.cnt <= FULL_CNT)
    else $error("fifo count beyond depth");
endmodule // ddc_fifo

/* File: test/ddc_host_model.sv */
`timescale 1ns/1ps
// serial host: frames sent top bit first, clock idles high between frames
module ddc_host_model (
  output logic sclk,
  output logic sync_n,
  output logic din
);
  // idle levels at time zero
  initial
  begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end

  // send the low n bits of w; a short n makes an aborted frame
  task automatic frame(input logic [31:0] w, input int n);
    #1.3; // odd offset keeps the link unrelated to the system clock
    sync_n = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = w[i];
      #24 sclk = 1'b0;
      #24 sclk = 1'b1;
    end
    // released line flips, so a stale bit never looks good
    din = ~din;
    #24 sync_n = 1'b1;
    #100; // frame select stays high well past the gap the block needs
  endtask
endmodule // ddc_host_model

/* File: test/test_dual_dac_command_decoder.sv */
`timescale 1ns/1ps
module test_dual_dac_command_decoder;
  import ddc_pkg::*;
  // a command word and the state it should leave behind
  typedef struct packed {
    logic [23:0] w;
    logic [17:0] da;
    logic [17:0] db;
    logic [17:0] ba;
    logic [17:0] bb;
  } ddc_row_s;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sclk, sync_n, din, link_busy, pready, pslverr;
  logic [31:0] prdata;
  ddc_analog_s ana_a, ana_b;
  int bad_count = 0;
  int cmp_count = 0;
  int na = 0; // conversion pulses seen per channel
  int nb = 0;
  int pa;
  int pb;
  logic [31:0] rd; // last apb read data and error
  logic er;
  ddc_row_s rows [7];

  always #2 clock = ~clock;

  // count conversion starts, one per load
  always @(posedge clock)
  begin
    na <= na + (ana_a.conv_start === 1'b1);
    nb <= nb + (ana_b.conv_start === 1'b1);
  end

  ddc_host_model host (.sclk(sclk), .sync_n(sync_n), .din(din));

  ddc_dual_dac_ctrl uut (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .din(din),
    .link_busy(link_busy), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ana_a(ana_a), .ana_b(ana_b)
  );

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      bad_count++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // analog drive expected from a dac register value
  task automatic anachk(input ddc_analog_s s, input logic [17:0] e);
    chk({s.amp_on, s.sw_1k, s.sw_100k, s.code},
        {e[17:16] == 2'h0, e[17:16] == 2'h1, e[17:16] == 2'h2, e[15:0]});
  endtask

  // execution lands a handful of clocks after the last edge
  task automatic settle();
    repeat (12) @(posedge clock);
  endtask

  // hang guard
  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end

  initial
  begin
    rows[0] = '{24'h001234, 18'h00000, 18'h00000, 18'h01234, 18'h00000};
    rows[1] = '{24'h34ABCD, 18'h01234, 18'h0ABCD, 18'h01234, 18'h0ABCD};
    rows[2] = '{24'h010055, 18'h01234, 18'h0ABCD, 18'h10055, 18'h0ABCD};
    rows[3] = '{24'h160077, 18'h10055, 18'h0ABCD, 18'h10055, 18'h20077};
    rows[4] = '{24'h270099, 18'h10055, 18'h30099, 18'h10055, 18'h30099};
    rows[5] = '{24'h184321, 18'h04321, 18'h30099, 18'h04321, 18'h30099};
    rows[6] = '{24'h260042, 18'h04321, 18'h20042, 18'h04321, 18'h20042};
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    anachk(ana_a, 18'h0);
    anachk(ana_b, 18'h0);
    for (int i = 0; i < 4; i++)
      rdchk(REG_DAC_A + 8'(4 * i), 32'h0);
    chk(link_busy, 1'b0);
    $display("reset test done");
    foreach (rows[i])
    begin
      pa = na;
      pb = nb;
      host.frame({8'h00, rows[i].w}, 24);
      settle();
      chk(na - pa, rows[i].w[20]);
      chk(nb - pb, rows[i].w[21]);
      rdchk(REG_DAC_A, rows[i].da);
      rdchk(REG_DAC_B, rows[i].db);
      rdchk(REG_BUF_A, rows[i].ba);
      rdchk(REG_BUF_B, rows[i].bb);
      anachk(ana_a, rows[i].da);
      anachk(ana_b, rows[i].db);
    end
    $display("table test done");
    // frame cut short after 12 bits of a load command
    pa = na;
    host.frame(32'h105, 12);
    settle();
    chk(na - pa, 32'h0);
    rdchk(REG_BUF_A, 18'h04321);
    // eight extra bits after the word in one frame
    host.frame(32'h00BEEFFF, 32);
    settle();
    rdchk(REG_BUF_A, 18'h0BEEF);
    rdchk(REG_DAC_A, 18'h04321);
    $display("frame test done");
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    // hold execution, overfill the word buffer, then drain it
    apb(1'b1, REG_CTRL, 32'h1);
    rdchk(REG_CTRL, 32'h1);
    repeat (9) host.frame(32'h001111, 24);
    settle();
    chk(link_busy, 1'b1);
    rdchk(REG_STATUS, 32'h801);
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (40) @(posedge clock);
    chk(link_busy, 1'b0);
    rdchk(REG_STATUS, 32'h1);
    apb(1'b1, REG_STATUS, 32'h1);
    rdchk(REG_STATUS, 32'h0);
    rdchk(REG_BUF_A, 18'h01111);
    $display("buffer test done");
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rdchk(REG_DAC_B, 32'h0);
    rdchk(REG_BUF_A, 32'h0);
    anachk(ana_a, 18'h0);
    anachk(ana_b, 18'h0);
    // first load after reset with no buffer a write gives zero-scale on a
    pa = na;
    pb = nb;
    host.frame(32'h0034FFFF, 24);
    settle();
    chk(na - pa, 32'h1);
    chk(nb - pb, 32'h1);
    rdchk(REG_DAC_A, 32'h0);
    rdchk(REG_DAC_B, 32'h0FFFF);
    anachk(ana_a, 18'h0);
    $display("second reset test done");
    final_report();
  end
endmodule // test_dual_dac_command_decoder
